// *** common/word_loader_pkg.sv ***
// shared constants for the six-channel decimating word loader
package word_loader_pkg;
    localparam int WORD_W = 12;
    localparam int CHANNELS = 6;
    localparam logic [2:0] FIRST_CH = 3'h0;
    localparam logic [2:0] LAST_CH = 3'h5;
    localparam logic [11:0] WORD_RESET = 12'h000;
    localparam int SYNC_STAGES = 3;
    localparam logic [2:0] LOAD_EDGES = 3'h6;
endpackage : word_loader_pkg

// *** common/edge_if.sv ***
// rise and fall events from the edge finder to the loader core
`timescale 1ns/100ps
interface edge_if;
    logic rise;
    logic fall;
    logic [11:0] word;
    logic begin_lvl;
    logic strobe_lvl;
    logic edge_sel;
    modport source (output rise, output fall, output word, output begin_lvl, output strobe_lvl, output edge_sel);
    modport sink (input rise, input fall, input word, input begin_lvl, input strobe_lvl, input edge_sel);
endinterface : edge_if

// *** hdl/pin_sync.sv ***
// three-stage synchroniser with agreement filter for a W-bit group of pins
`timescale 1ns/100ps
module pin_sync
    import word_loader_pkg::*;
#(
    parameter int W = 1
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] level
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end
        else
        begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // a bit changes only once stages two and three agree
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            level <= '0;
        else
        begin
            for (int i = 0; i < W; i++)
            begin
                if (s2_reg[i] == s3_reg[i])
                    level[i] <= s3_reg[i];
            end
        end
    end
endmodule : pin_sync

// *** hdl/edge_finder.sv ***
// samples the link clock and all link pins, reports clock edges
`timescale 1ns/100ps
module edge_finder
    import word_loader_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic link_clk,
    input wire logic [WORD_W-1:0] pixel_word_in,
    input wire logic sequence_begin,
    input wire logic output_update_strobe,
    input wire logic edge_select,
    edge_if.source ev
);
    localparam int PW = WORD_W + 4;
    logic [PW-1:0] lvl;
    logic clk_prev_reg;

    // data travels through the same depth as the clock so it is sampled as it stood at the edge
    pin_sync #(.W(PW)) u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .pin({link_clk, edge_select, output_update_strobe, sequence_begin, pixel_word_in}),
        .level(lvl)
    );

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            clk_prev_reg <= 1'b0;
        else
            clk_prev_reg <= lvl[PW-1];
    end

    assign ev.rise = lvl[PW-1] & ~clk_prev_reg;
    assign ev.fall = ~lvl[PW-1] & clk_prev_reg;
    assign ev.word = lvl[WORD_W-1:0];
    assign ev.begin_lvl = lvl[WORD_W];
    assign ev.strobe_lvl = lvl[WORD_W+1];
    assign ev.edge_sel = lvl[WORD_W+2];
endmodule : edge_finder

// *** hdl/word_loader.sv ***
// six-channel decimating word loader: sequencing, channel latches, output stage
// Behaviour
// - twelve-bit pixel word, bit 11 most significant
// - six 12-bit channels filled from one bus
// - edge select high rising, low falling active
// - load only on active edges
// - rising mode: start needs start at previous rise
// - falling mode: start needs start at previous fall
// - direction low first channel 0, high 5
// - strobe on rise moves data next fall
// - invert selects output region, passed to stage
// - standby disables the logic
// - a start loads six words on six edges
// - pointer up from 0 or down from 5
// - all six outputs update together
// - standby discards channel and output words
`timescale 1ns/100ps
module word_loader
    import word_loader_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic link_clk,
    input wire logic [WORD_W-1:0] pixel_word_in,
    input wire logic sequence_begin,
    input wire logic output_update_strobe,
    input wire logic edge_select,
    input wire logic load_direction,
    input wire logic polarity_invert,
    input wire logic low_power_request,
    output logic [WORD_W-1:0] column_drive_out [CHANNELS],
    output logic region_upper,
    output logic loading,
    output logic standby_active
);
    typedef enum logic [0:0] {IDLE, LOAD} load_state_e;

    edge_if ev ();
    logic [2:0] misc_lvl;
    logic active_edge;
    logic begin_armed_reg;
    logic xfer_pending_reg;
    logic [2:0] ptr_reg;
    logic [2:0] count_reg;
    logic dir_reg;
    load_state_e state_reg;
    logic [WORD_W-1:0] latch_reg [CHANNELS];
    logic start_now;

    function automatic logic [2:0] step_ptr(input logic [2:0] p, input logic down);
        step_ptr = down ? 3'(p - 3'h1) : 3'(p + 3'h1);
    endfunction : step_ptr

    edge_finder u_edges (
        .clk(clk),
        .arst_n(arst_n),
        .link_clk(link_clk),
        .pixel_word_in(pixel_word_in),
        .sequence_begin(sequence_begin),
        .output_update_strobe(output_update_strobe),
        .edge_select(edge_select),
        .ev(ev)
    );

    // quasi-static controls get the same three-stage filter
    pin_sync #(.W(3)) u_misc (
        .clk(clk),
        .arst_n(arst_n),
        .pin({load_direction, polarity_invert, low_power_request}),
        .level(misc_lvl)
    );

    wire standby = misc_lvl[0];

    assign active_edge = ev.edge_sel ? ev.rise : ev.fall;
    // start is honoured only if it was seen high at the previous active edge
    assign start_now = active_edge & begin_armed_reg;

    fall_polarity_a: assert property (@(posedge clk) disable iff (!arst_n)
        (active_edge && !ev.edge_sel) |-> ev.fall)
        else $error("wrong falling edge polarity");
    edges_apart_a: assert property (@(posedge clk) disable iff (!arst_n)
        1'b1 |-> !(ev.rise && ev.fall))
        else $error("rise and fall reported together");

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            begin_armed_reg <= 1'b0;
        else if (standby)
            begin_armed_reg <= 1'b0;
        else if (active_edge)
            begin_armed_reg <= ev.begin_lvl;
    end

    // outside standby, arming follows the start level at every active edge and nowhere else
    arm_on_edge_a: assert property (@(posedge clk) disable iff (!arst_n)
        (active_edge && !standby && ev.edge_sel) |=> (begin_armed_reg == $past(ev.begin_lvl)))
        else $error("start level not taken at rising edge");
    arm_on_fall_a: assert property (@(posedge clk) disable iff (!arst_n)
        (active_edge && !standby && !ev.edge_sel) |=> (begin_armed_reg == $past(ev.begin_lvl)))
        else $error("start level not taken at falling edge");
    arm_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
        (!active_edge && !standby) |=> $stable(begin_armed_reg))
        else $error("start level taken off an active edge");
    fall_start_arm_a: assert property (@(posedge clk) disable iff (!arst_n)
        (state_reg == IDLE && !ev.edge_sel && !begin_armed_reg) |=> (state_reg == IDLE))
        else $error("falling sequence began without prior start");

    // sequencer: pointer and remaining-word count
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg <= IDLE;
            ptr_reg <= FIRST_CH;
            count_reg <= 3'h0;
            dir_reg <= 1'b0;
        end
        else if (standby)
            state_reg <= IDLE;
        else if (start_now)
        begin
            // the start edge itself carries the first word
            dir_reg <= misc_lvl[2];
            ptr_reg <= step_ptr(misc_lvl[2] ? LAST_CH : FIRST_CH, misc_lvl[2]);
            count_reg <= 3'(LOAD_EDGES - 3'h1);
            state_reg <= LOAD;
        end
        else if (active_edge && state_reg == LOAD)
        begin
            ptr_reg <= step_ptr(ptr_reg, dir_reg);
            count_reg <= 3'(count_reg - 3'h1);
            if (count_reg == 3'h1)
                state_reg <= IDLE;
        end
    end

    // pointer, count and direction move only as a sequence demands
    start_count_a: assert property (@(posedge clk) disable iff (!arst_n)
        (start_now && !standby) |=> (state_reg == LOAD && count_reg == 3'(LOAD_EDGES - 3'h1)))
        else $error("sequence did not start with five words left");
    count_step_a: assert property (@(posedge clk) disable iff (!arst_n)
        (active_edge && state_reg == LOAD && !start_now && !standby)
        |=> (count_reg == 3'($past(count_reg) - 3'h1)))
        else $error("word count did not step");
    up_step_a: assert property (@(posedge clk) disable iff (!arst_n)
        (active_edge && state_reg == LOAD && !start_now && !standby && !dir_reg)
        |=> (ptr_reg == 3'($past(ptr_reg) + 3'h1)))
        else $error("ascending pointer did not step up");
    down_step_a: assert property (@(posedge clk) disable iff (!arst_n)
        (active_edge && state_reg == LOAD && !start_now && !standby && dir_reg)
        |=> (ptr_reg == 3'($past(ptr_reg) - 3'h1)))
        else $error("descending pointer did not step down");
    dir_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
        (!start_now) |=> $stable(dir_reg))
        else $error("direction changed inside a sequence");
    idle_no_count_a: assert property (@(posedge clk) disable iff (!arst_n)
        (state_reg == IDLE && !start_now) |=> (state_reg == IDLE))
        else $error("sequence resumed without a start");

    // channel latches; all share the one word bus
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < CHANNELS; i++)
                latch_reg[i] <= WORD_RESET;
        end
        else if (standby)
        begin
            for (int i = 0; i < CHANNELS; i++)
                latch_reg[i] <= WORD_RESET;
        end
        else if (start_now)
            latch_reg[misc_lvl[2] ? LAST_CH : FIRST_CH] <= ev.word;
        else if (active_edge && state_reg == LOAD)
            latch_reg[ptr_reg] <= ev.word;
    end

    // only the pointed channel takes the word, and only on an active edge
    load_word_a: assert property (@(posedge clk) disable iff (!arst_n)
        (active_edge && state_reg == LOAD && !start_now && !standby)
        |=> (latch_reg[$past(ptr_reg)] == $past(ev.word)))
        else $error("word not stored in pointed channel");
    no_load_off_a: assert property (@(posedge clk) disable iff (!arst_n)
        (!active_edge && !standby) |=> ($stable(latch_reg[2]) && $stable(latch_reg[4])))
        else $error("latch written off an active edge");
    msb_kept_a: assert property (@(posedge clk) disable iff (!arst_n)
        (start_now && !standby && !misc_lvl[2]) |=> (latch_reg[0][WORD_W-1] == $past(ev.word[WORD_W-1])))
        else $error("word top bit lost");

    // transfer: strobe seen on a rise, applied at the following fall
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            xfer_pending_reg <= 1'b0;
        else if (standby)
            xfer_pending_reg <= 1'b0;
        else if (ev.rise)
            xfer_pending_reg <= ev.strobe_lvl;
        else if (ev.fall)
            xfer_pending_reg <= 1'b0;
    end

    // a strobe is taken on a rise and is spent by the very next fall
    strobe_on_rise_a: assert property (@(posedge clk) disable iff (!arst_n)
        (ev.rise && !standby) |=> (xfer_pending_reg == $past(ev.strobe_lvl)))
        else $error("strobe not sampled at rising edge");
    strobe_spent_a: assert property (@(posedge clk) disable iff (!arst_n)
        (ev.fall && !standby) |=> !xfer_pending_reg)
        else $error("pending transfer outlived its fall");

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < CHANNELS; i++)
                column_drive_out[i] <= WORD_RESET;
        end
        else if (standby)
        begin
            for (int i = 0; i < CHANNELS; i++)
                column_drive_out[i] <= WORD_RESET;
        end
        else if (ev.fall && xfer_pending_reg)
        begin
            // a word loaded on this same fall is not yet in the latch; it goes next transfer
            for (int i = 0; i < CHANNELS; i++)
                column_drive_out[i] <= latch_reg[i];
        end
        // otherwise hold, whatever the loader does
    end

    // all six words move in one clock, and outside standby nothing moves without a pending strobe
    all_outputs_a: assert property (@(posedge clk) disable iff (!arst_n)
        (ev.fall && xfer_pending_reg && !standby)
        |=> (column_drive_out[3] == $past(latch_reg[3]) && column_drive_out[5] == $past(latch_reg[5])))
        else $error("outputs not updated together");
    no_strobe_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
        (!xfer_pending_reg && !standby) |=> ($stable(column_drive_out[0]) && $stable(column_drive_out[4])))
        else $error("outputs changed with no pending transfer");

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            region_upper <= 1'b0;
            loading <= 1'b0;
            standby_active <= 1'b0;
        end
        else
        begin
            region_upper <= misc_lvl[1];
            loading <= (state_reg == LOAD) & ~standby;
            standby_active <= standby;
        end
    end

    // status outputs follow the filtered controls one clock later
    region_upper_a: assert property (@(posedge clk) disable iff (!arst_n)
        misc_lvl[1] |=> region_upper)
        else $error("upper region not selected");
    region_lower_a: assert property (@(posedge clk) disable iff (!arst_n)
        !misc_lvl[1] |=> !region_upper)
        else $error("lower region not selected");
    standby_flag_a: assert property (@(posedge clk) disable iff (!arst_n)
        standby |=> (standby_active && !loading))
        else $error("standby not reported");
    standby_quiet_a: assert property (@(posedge clk) disable iff (!arst_n)
        standby |=> (!begin_armed_reg && !xfer_pending_reg && state_reg == IDLE))
        else $error("standby left logic running");
    standby_empty_a: assert property (@(posedge clk) disable iff (!arst_n)
        standby |=> (latch_reg[0] == WORD_RESET && column_drive_out[5] == WORD_RESET))
        else $error("standby kept a stored word");
    loading_flag_a: assert property (@(posedge clk) disable iff (!arst_n)
        (state_reg == IDLE) |=> !loading)
        else $error("loading shown while idle");

    transfer_on_fall_a: assert property (@(posedge clk) disable iff (!arst_n)
        (ev.fall && xfer_pending_reg && !standby) |=> (column_drive_out[0] == $past(latch_reg[0])))
        else $error("transfer did not copy latch on fall");
    hold_outputs_a: assert property (@(posedge clk) disable iff (!arst_n)
        (!ev.fall && !standby) |=> $stable(column_drive_out[5]))
        else $error("outputs changed without transfer");
    standby_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
        standby |=> (latch_reg[3] == WORD_RESET && column_drive_out[2] == WORD_RESET))
        else $error("standby left stored words");
    first_channel_a: assert property (@(posedge clk) disable iff (!arst_n)
        (start_now && !standby && !misc_lvl[2]) |=> (latch_reg[0] == $past(ev.word) && ptr_reg == 3'h1))
        else $error("ascending start not at channel 0");
    descend_start_a: assert property (@(posedge clk) disable iff (!arst_n)
        (start_now && !standby && misc_lvl[2]) |=> (latch_reg[5] == $past(ev.word) && ptr_reg == 3'h4))
        else $error("descending start not at channel 5");
    start_needs_arm_a: assert property (@(posedge clk) disable iff (!arst_n)
        (state_reg == IDLE && !begin_armed_reg) |=> (state_reg == IDLE))
        else $error("sequence began without prior start");
    six_edges_a: assert property (@(posedge clk) disable iff (!arst_n)
        (state_reg == LOAD && active_edge && count_reg == 3'h1 && !start_now && !standby)
        |=> (state_reg == IDLE))
        else $error("sequence length not six edges");
    idle_ignores_a: assert property (@(posedge clk) disable iff (!arst_n)
        (state_reg == IDLE && !start_now) |=> $stable(latch_reg[1]) || $past(standby))
        else $error("latch written outside a sequence");
    edge_polarity_a: assert property (@(posedge clk) disable iff (!arst_n)
        (active_edge && ev.edge_sel) |-> ev.rise)
        else $error("wrong active edge polarity");
endmodule : word_loader

// *** tb/pixel_source.sv ***
// image processor model: link clock, pixel words, start and transfer levels
`timescale 1ns/100ps
module pixel_source
    import word_loader_pkg::*;
(
    output logic link_clk,
    output logic [WORD_W-1:0] pixel_word_in,
    output logic sequence_begin,
    output logic output_update_strobe
);
    initial
    begin
        link_clk = 1'b0;
        pixel_word_in = 12'h000;
        sequence_begin = 1'b0;
        output_update_strobe = 1'b0;
    end

    // pins move only at non-active edges, so each active edge sees a half period of settled data
    task automatic frame(input logic act, input logic st, input logic [WORD_W-1:0] w [CHANNELS]);
        // off the system clock grid, so no pin moves in the time step of a sampling edge
        #0.2;
        for (int k = 0; k < 8; k++)
        begin
            link_clk = ~act;
            sequence_begin = st && (k == 0);
            pixel_word_in = (k >= 1 && k <= 6) ? w[k-1] : ~pixel_word_in;
            #24 link_clk = act;
            #24;
        end
        // clock stands still between frames; released bus is back at the last word, w[5]
        link_clk = ~act;
        pixel_word_in = ~pixel_word_in;
        #24;
    endtask : frame

    task automatic xfer();
        #0.2;
        if (link_clk)
        begin
            link_clk = 1'b0;
            #24;
        end
        output_update_strobe = 1'b1;
        #24 link_clk = 1'b1;
        #24 link_clk = 1'b0;
        output_update_strobe = 1'b0;
        #24;
    endtask : xfer
endmodule : pixel_source

// *** tb/six_channel_decimating_word_loader_tb_top.sv ***
// self-checking bench for the six-channel decimating word loader
`timescale 1ns/100ps
module six_channel_decimating_word_loader_tb_top
    import word_loader_pkg::*;
;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic link_clk;
    logic [WORD_W-1:0] pixel_word_in;
    logic sequence_begin;
    logic output_update_strobe;
    logic edge_select = 1'b1;
    logic load_direction = 1'b0;
    logic polarity_invert = 1'b0;
    logic low_power_request = 1'b0;
    logic [WORD_W-1:0] column_drive_out [CHANNELS];
    logic region_upper;
    logic loading;
    logic standby_active;
    int err_total = 0;
    int total_checks = 0;
    logic [WORD_W-1:0] wa [CHANNELS] = '{12'h801, 12'h042, 12'hF03, 12'h1A4, 12'h5C5, 12'h7E6};
    logic [WORD_W-1:0] wb [CHANNELS] = '{12'hA5A, 12'h3C3, 12'h0F0, 12'hFFF, 12'h001, 12'h800};
    logic [WORD_W-1:0] zero [CHANNELS] = '{default: 12'h000};

    always #2.5 clk = ~clk;

    word_loader dut_u (.clk(clk), .arst_n(arst_n), .link_clk(link_clk), .pixel_word_in(pixel_word_in),
        .sequence_begin(sequence_begin), .output_update_strobe(output_update_strobe),
        .edge_select(edge_select), .load_direction(load_direction), .polarity_invert(polarity_invert),
        .low_power_request(low_power_request), .column_drive_out(column_drive_out),
        .region_upper(region_upper), .loading(loading), .standby_active(standby_active));

    pixel_source src_u (.link_clk(link_clk), .pixel_word_in(pixel_word_in), .sequence_begin(sequence_begin),
        .output_update_strobe(output_update_strobe));

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic chk_out(input logic [WORD_W-1:0] w [CHANNELS], input logic dir);
        for (int i = 0; i < CHANNELS; i++)
            chk(column_drive_out[i], dir ? w[CHANNELS-1-i] : w[i], "output word");
    endtask : chk_out

    task automatic load_rise_up();
        int busy;
        busy = 0;
        edge_select = 1'b1;
        load_direction = 1'b0;
        step(10);
        fork
            src_u.frame(1'b1, 1'b1, wa);
            // looked at a step after the edge, once the flag has settled
            repeat (150)
            begin
                step(1);
                busy += (loading === 1'b1);
            end
        join
        step(10);
        chk((busy >= 44 && busy <= 52) ? 12'h001 : 12'h000, 12'h001, "load span");
        chk({11'h000, loading}, 12'h000, "loading after sixth");
        src_u.xfer();
        step(10);
        chk_out(wa, 1'b0);
    endtask : load_rise_up

    task automatic load_fall_down();
        edge_select = 1'b0;
        load_direction = 1'b1;
        step(10);
        src_u.frame(1'b0, 1'b1, wb);
        step(10);
        chk_out(wa, 1'b0);
        src_u.xfer();
        step(10);
        chk_out(wb, 1'b1);
    endtask : load_fall_down

    task automatic no_start();
        edge_select = 1'b1;
        load_direction = 1'b0;
        step(10);
        src_u.frame(1'b1, 1'b0, wa);
        src_u.xfer();
        step(10);
        chk_out(wb, 1'b1);
    endtask : no_start

    task automatic invert();
        polarity_invert = 1'b1;
        step(8);
        chk({11'h000, region_upper}, 12'h001, "region high");
        polarity_invert = 1'b0;
        step(8);
        chk({11'h000, region_upper}, 12'h000, "region low");
    endtask : invert

    task automatic standby();
        low_power_request = 1'b1;
        step(8);
        chk({11'h000, standby_active}, 12'h001, "standby on");
        chk_out(zero, 1'b0);
        src_u.frame(1'b1, 1'b1, wb);
        src_u.xfer();
        step(10);
        chk_out(zero, 1'b0);
        low_power_request = 1'b0;
        step(8);
        chk({11'h000, standby_active}, 12'h000, "standby off");
        chk_out(zero, 1'b0);
    endtask : standby

    initial
    begin
        #200us;
        err_total++;
        report_and_stop();
    end

    initial
    begin
        step(10);
        arst_n = 1'b1;
        step(5);
        chk_out(zero, 1'b0);
        load_rise_up();
        load_fall_down();
        no_start();
        invert();
        standby();
        load_rise_up();
        report_and_stop();
    end
endmodule : six_channel_decimating_word_loader_tb_top
